// *** agr_pkg.sv ***
// Package of offsets, fields and types for the gain/RTD and error mask registers
package agr_pkg;

  // Register addresses on the configuration port
  localparam logic [3:0] AGR_ADDR_TOP_STATUS  = 4'h0;
  localparam logic [3:0] AGR_ADDR_GAIN_RTD    = 4'h5;
  localparam logic [3:0] AGR_ADDR_ERR_MASK    = 4'h6;
  localparam logic [3:0] AGR_ADDR_DETAIL      = 4'h7;

  // Reset values
  localparam logic [15:0] AGR_GAIN_RTD_RESET  = 16'h0000;
  localparam logic [15:0] AGR_ERR_MASK_RESET  = 16'h0000;
  localparam logic [15:0] AGR_DETAIL_RESET    = 16'h0000;

  // Gain/RTD control field positions
  localparam int AGR_WIRING_BIT    = 15;
  localparam int AGR_COMP_MSB      = 14;
  localparam int AGR_COMP_LSB      = 12;
  localparam int AGR_EXC_MSB       = 11;
  localparam int AGR_EXC_LSB       = 9;
  localparam int AGR_EXT_RES_BIT   = 8;
  localparam int AGR_GAIN_MSB      = 7;
  localparam int AGR_GAIN_LSB      = 4;

  // Error bit positions, shared by mask and detail status
  localparam int AGR_NEG_UV_BIT    = 11;
  localparam int AGR_POS_UV_BIT    = 10;
  localparam int AGR_NEG_OV_BIT    = 9;
  localparam int AGR_POS_OV_BIT    = 8;
  localparam int AGR_EXC_CMP_BIT   = 7;
  localparam int AGR_COMP_CMP_BIT  = 6;
  localparam int AGR_FLD_OC_BIT    = 2;
  localparam int AGR_IN_OC_BIT     = 1;
  localparam int AGR_SUMMARY_BIT   = 0;

  // Writable bits of each register
  localparam logic [15:0] AGR_GAIN_RTD_WMASK  = 16'hfff0;
  localparam logic [15:0] AGR_ERR_MASK_WMASK  = 16'h0fc6;

  // Decoded gain/RTD configuration
  typedef struct packed {
    logic       wiring_style_select;                 // 0 4-wire, 1 2/3-wire
    logic [2:0] compensation_current_code;           // 000 off
    logic [2:0] excitation_current_code;             // 000 off
    logic       external_reference_resistor_select;  // 0 internal
    logic [3:0] channel_gain_code;                   // 0000 min gain
  } agr_cfg_type;

  // Raw diagnostic conditions from the analog front end
  typedef struct packed {
    logic neg_input_undervoltage;
    logic pos_input_undervoltage;
    logic neg_input_overvoltage;
    logic pos_input_overvoltage;
    logic excitation_compliance_error;
    logic compensation_compliance_error;
    logic field_supply_overcurrent;
    logic input_overcurrent;
  } agr_err_type;

endpackage : agr_pkg

// *** agr_regs.sv ***
// Gain/RTD control and error alert mask registers with error summary
// Functional notes
// [RQ1] Bit 15 selects 4-wire or 2/3-wire
// [RQ2] Bits 14:12, 11:9 current codes, 000 off
// [RQ3] Bit 8 selects internal or external resistor
// [RQ4] Bits 7:4 gain code, 0000 minimum
// [RQ5] Gain/RTD register resets to zero
// [RQ6] One mask bit per error, 1 suppresses
// [RQ7] Summary bit is OR of unmasked errors
// [RQ8] Alert pin uses same masked sum
// [RQ9] Error mask register resets to zero
// [RQ10] Detail flags latch until detail read
// [RQ11] Reserved bits read zero, ignore writes
// [RQ12] Mask change acts within one clock
module agr_regs (
  input  wire logic                clk_sys,      // Register clock
  input  wire logic                sys_rst,      // Async reset, active high
  input  wire logic                reg_wr,       // Write strobe
  input  wire logic                reg_rd,       // Read strobe
  input  wire logic [3:0]          reg_addr,     // Register address
  input  wire logic [15:0]         reg_wdata,    // Write data
  input  wire agr_pkg::agr_err_type err_raw,     // Raw error conditions
  output logic      [15:0]         reg_rdata,    // Read data
  output logic                     reg_rvalid,   // Read data valid pulse
  output agr_pkg::agr_cfg_type     cfg,          // Gain/RTD configuration
  output logic                     summary_error_bit, // Masked error sum
  output logic                     err_alert     // Alert pin, active high
);
  import agr_pkg::*;

  logic [15:0] gain_rtd_q, gain_rtd_d;
  logic [15:0] mask_q,     mask_d;
  logic [15:0] detail_q,   detail_d;
  logic [15:0] rdata_q,    rdata_d;
  logic        rvalid_q,   rvalid_d;
  logic        sum_q,      sum_d;
  logic [15:0] err_vec;
  logic        sum_now;

  // Spread raw conditions onto register bit positions
  always_comb begin
    err_vec                   = 16'h0000;
    err_vec[AGR_NEG_UV_BIT]   = err_raw.neg_input_undervoltage;
    err_vec[AGR_POS_UV_BIT]   = err_raw.pos_input_undervoltage;
    err_vec[AGR_NEG_OV_BIT]   = err_raw.neg_input_overvoltage;
    err_vec[AGR_POS_OV_BIT]   = err_raw.pos_input_overvoltage;
    err_vec[AGR_EXC_CMP_BIT]  = err_raw.excitation_compliance_error;
    err_vec[AGR_COMP_CMP_BIT] = err_raw.compensation_compliance_error;
    err_vec[AGR_FLD_OC_BIT]   = err_raw.field_supply_overcurrent;
    err_vec[AGR_IN_OC_BIT]    = err_raw.input_overcurrent;
  end

  // Masked error sum from the current mask contents
  assign sum_now = |(err_vec & ~mask_q & AGR_ERR_MASK_WMASK); // [RQ6] [RQ7]

  // Register write and detail latch next state
  always_comb begin
    gain_rtd_d = gain_rtd_q;
    mask_d     = mask_q;
    detail_d   = detail_q;
    if (reg_wr && reg_addr == AGR_ADDR_GAIN_RTD) begin
      gain_rtd_d = reg_wdata & AGR_GAIN_RTD_WMASK; // [RQ11]
    end
    if (reg_wr && reg_addr == AGR_ADDR_ERR_MASK) begin
      mask_d = reg_wdata & AGR_ERR_MASK_WMASK; // [RQ6] [RQ11]
    end
    if (reg_rd && reg_addr == AGR_ADDR_DETAIL) begin
      detail_d = 16'h0000; // [RQ10]
    end
    // New events win over the read clear, mask applied only to the summary bit
    detail_d = detail_d | (err_vec & AGR_ERR_MASK_WMASK); // [RQ10]
    detail_d[AGR_SUMMARY_BIT] = detail_d[AGR_SUMMARY_BIT] | sum_now;
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = reg_rd;
    sum_d    = sum_now; // [RQ12]
    if (reg_rd) begin
      unique case (reg_addr)
        AGR_ADDR_TOP_STATUS: rdata_d = {15'h0000, sum_q}; // [RQ7]
        AGR_ADDR_GAIN_RTD:   rdata_d = gain_rtd_q;       // [RQ11]
        AGR_ADDR_ERR_MASK:   rdata_d = mask_q;           // [RQ11]
        AGR_ADDR_DETAIL:     rdata_d = detail_q;
        default:             rdata_d = 16'h0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gain_rtd_q <= AGR_GAIN_RTD_RESET; // [RQ5]
      mask_q     <= AGR_ERR_MASK_RESET; // [RQ9]
      detail_q   <= AGR_DETAIL_RESET;
      rdata_q    <= 16'h0000;
      rvalid_q   <= 1'b0;
      sum_q      <= 1'b0;
    end else begin
      gain_rtd_q <= gain_rtd_d;
      mask_q     <= mask_d;
      detail_q   <= detail_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      sum_q      <= sum_d;
    end
  end

  // Configuration fields straight from the register
  assign cfg.wiring_style_select                = gain_rtd_q[AGR_WIRING_BIT];            // [RQ1]
  assign cfg.compensation_current_code          = gain_rtd_q[AGR_COMP_MSB:AGR_COMP_LSB]; // [RQ2]
  assign cfg.excitation_current_code            = gain_rtd_q[AGR_EXC_MSB:AGR_EXC_LSB];   // [RQ2]
  assign cfg.external_reference_resistor_select = gain_rtd_q[AGR_EXT_RES_BIT];           // [RQ3]
  assign cfg.channel_gain_code                  = gain_rtd_q[AGR_GAIN_MSB:AGR_GAIN_LSB]; // [RQ4]

  // Summary and alert from one flop
  assign summary_error_bit = sum_q; // [RQ7]
  assign err_alert         = sum_q; // [RQ8]
  assign reg_rdata         = rdata_q;
  assign reg_rvalid        = rvalid_q;

endmodule // agr_regs

// *** agr_regs_props.sv ***
// Checker for the gain/RTD and mask registers
module agr_regs_props (
  input wire logic clk_sys, sys_rst, reg_wr, reg_rd, // Clock, reset, strobes
  input wire logic [3:0] reg_addr,                   // Address
  input wire logic [15:0] reg_wdata, reg_rdata,      // Data
  input wire agr_pkg::agr_err_type err_raw,          // Raw errors
  input wire logic summary_error_bit, err_alert,     // Error outputs
  input wire agr_pkg::agr_cfg_type cfg               // Configuration
);
  import agr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire w5 = reg_wr && reg_addr == 4'h5;
  wire r5 = reg_rd && reg_addr == 4'h5;
  wire r6 = reg_rd && reg_addr == 4'h6;
  // Fields, summary and reserved bits
  a_wire_bit: assert property (w5 |=> cfg[11] == $past(reg_wdata[15])) else $error("bad");
  a_cur_codes: assert property (w5 |=> cfg[10:5] == $past(reg_wdata[14:9])) else $error("bad");
  a_res_bit: assert property (w5 |=> cfg[4] == $past(reg_wdata[8])) else $error("bad");
  a_gain_code: assert property (w5 |=> cfg[3:0] == $past(reg_wdata[7:4])) else $error("bad");
  a_sum_cause: assert property (summary_error_bit |-> $past(|err_raw)) else $error("bad");
  a_alert_same: assert property (err_alert == summary_error_bit) else $error("bad");
  a_gain_resv: assert property (r5 |=> reg_rdata[3:0] == 4'h0) else $error("bad");
  a_mask_resv: assert property (r6 |=> (reg_rdata & 16'hf039) == 16'h0) else $error("bad");
  // Main scenarios reached
  cover property (w5);
  cover property (err_alert);
  cover property (r6);
endmodule // agr_regs_props

// *** agr_host.sv ***
// Host model on the register strobe port
module agr_host (
  input wire logic clk_sys,         // Register clock
  output logic reg_wr, reg_rd,      // Strobes
  output logic [3:0] reg_addr,      // Address
  output logic [15:0] reg_wdata,    // Write data
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic reg_rvalid       // Read data valid pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // One write, then an idle cycle; stale data inverted
  task wr(logic [3:0] a, logic [15:0] v);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    @(negedge clk_sys);
    {reg_wr, reg_wdata} = {1'b0, ~v};
    @(negedge clk_sys);
  endtask
  // One read, data taken once settled
  task rd(logic [3:0] a, output logic [15:0] v, output logic f);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys);
    reg_rd = 1'b0;
    v = reg_rdata;
    f = reg_rvalid;
    @(negedge clk_sys);
  endtask
endmodule // agr_host

// *** tb_top.sv ***
// Testbench for the gain/RTD and mask registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import agr_pkg::*;
  logic clk_sys = 0, sys_rst = 1, reg_wr, reg_rd, reg_rvalid, summary_error_bit, err_alert;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  agr_err_type err_raw = '0;
  agr_cfg_type cfg;
  int mismatches = 0, n_checks = 0;
  always #25 clk_sys = ~clk_sys;
  agr_host i_agr_host (.*);
  agr_regs i_agr_regs (.*);
  task chk(string n, logic [15:0] e, logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task rdchk(logic [3:0] a, logic [15:0] e);
    logic [15:0] v;
    logic        f;
    i_agr_host.rd(a, v, f);
    chk("rdata", e, v);
    chk("rvalid", 16'h1, {15'h0, f});
    chk("rvalid_end", 16'h0, {15'h0, reg_rvalid});
  endtask
  // Each mask bit against its own error
  task t_mask;
    logic [15:0] m;
    for (int k = 0; k < 8; k++) begin
      m = 16'h1 << (k < 2 ? k + 1 : k + 4);
      err_raw = 8'h1 << k;
      i_agr_host.wr(4'h6, m);
      chk("alert", 16'h0, {15'h0, err_alert});
      i_agr_host.wr(4'h6, ~m);
      chk("sum", 16'h1, {15'h0, summary_error_bit});
      rdchk(4'h0, 16'h0001);
    end
  endtask
  // Gain/RTD fields, reserved bits, reset values
  task t_fields;
    logic [15:0] v [5] = '{16'h8000, 16'h7000, 16'h0e00, 16'h0100, 16'hffff};
    rdchk(4'h6, 16'h0000);
    rdchk(4'h3, 16'h0000);
    chk("cfg", 16'h0000, 16'(cfg));
    foreach (v[i]) begin
      i_agr_host.wr(4'h5, v[i]);
      chk("cfg", {4'h0, v[i][15:4]}, 16'(cfg));
      rdchk(4'h5, v[i] & 16'hfff0);
    end
  endtask
  // Masked pulse still latched in detail
  task t_detail;
    err_raw = 8'h00;
    i_agr_host.wr(4'h6, 16'hffff);
    rdchk(4'h6, 16'h0fc6);
    rdchk(4'h7, 16'h0fc7);
    err_raw = 8'h01;
    @(negedge clk_sys);
    err_raw = 8'h00;
    rdchk(4'h7, 16'h0002);
    rdchk(4'h7, 16'h0000);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 0;
    @(negedge clk_sys);
    t_fields();
    t_mask();
    t_detail();
    stop_test();
  end
  // Watchdog
  initial begin
    #100us;
    mismatches++;
    stop_test();
  end
endmodule // tb_top
bind agr_regs agr_regs_props i_agr_regs_props (.*);
